// ---- design/acs_converter_ctrl.v ----
// Converter input select, result presentation and sleep-time conversion control
//
// Chosen here: the APB register port.
`default_nettype none
`include "acs_map.vh"
// Contract
// - Entering low-noise or idle sleep starts a conversion once the CPU halts.
// - Sleep conversion completion wakes the CPU and requests the completion handler.
// - Earlier wake serves other interrupt; completion request still raised later.
// - Other sleep modes do not switch the converter off.
// - Result equals input times 1024 over reference, 0x000 to 0x3FF.
// - Result readable from low and high registers once done flag set.
// - Channel code 1000 routes and enables the temperature sensor.
// - Reference field bits 7:6: external, supply, reserved, internal 1.1V.
// - Reference change during conversion applies only after completion; in auto mode it waits for disable.
// - Left-align bit 5 changes result presentation immediately.
// - Bit 4 of the select register always reads zero.
// - Completion writes result, sets done flag, clears start in single mode.
// - Start bit reads one for the whole conversion.
// - Channel field: 0-7 external, 8 temperature, E bandgap, F ground.
module acs_converter_ctrl
(
  input  wire        clock_i,
  input  wire        rst_n_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  input  wire [9:0]  sample_i,
  input  wire [1:0]  sleep_mode_i,
  input  wire        cpu_halted_i,
  output reg  [3:0]  channel_o,
  output reg  [1:0]  reference_o,
  output reg         int_ref_on_o,
  output reg         temp_sensor_on_o,
  output reg         converter_on_o,
  output reg         busy_o,
  output reg         done_irq_o,
  output reg         wake_o,
  output reg         irq_o
);

  localparam ST_IDLE = 1'b0;
  localparam ST_CONV = 1'b1;

  // Read selector codes returned by the address decoder
  localparam RD_NONE  = 3'h0;
  localparam RD_SEL   = 3'h1;
  localparam RD_CTRL  = 3'h2;
  localparam RD_LOW   = 3'h3;
  localparam RD_HIGH  = 3'h4;
  localparam RD_STAT  = 3'h5;
  localparam RD_MASK  = 3'h6;
  localparam RD_SLEEP = 3'h7;

  reg        state_reg;
  reg [7:0]  select_reg;
  reg [7:0]  control_reg;
  reg [9:0]  result_reg;
  reg [7:0]  count_reg;
  reg        first_reg;
  reg [3:0]  chan_lat_reg;
  reg [1:0]  ref_lat_reg;
  reg        sleep_conv_reg;
  reg        halt_s1_reg;
  reg        halt_s2_reg;
  reg [1:0]  mode_s1_reg;
  reg [1:0]  mode_s2_reg;
  reg [9:0]  samp_s1_reg;
  reg [9:0]  samp_s2_reg;
  reg        halt_prev_reg;
  reg [1:0]  irq_stat_reg;
  reg [1:0]  irq_mask_reg;
  reg [1:0]  sleep_ctrl_reg;

  wire        access    = psel_i & penable_i;
  wire        wr        = access & pwrite_i;
  wire        rd_setup  = psel_i & ~penable_i & ~pwrite_i;
  wire        halt_rise = halt_s2_reg & ~halt_prev_reg;
  wire        quiet_mode = (mode_s2_reg == `ACS_SLP_IDLE) || (mode_s2_reg == `ACS_SLP_LOWNOISE);
  wire        enabled   = control_reg[`ACS_CA_ENABLE];
  wire        single    = ~control_reg[`ACS_CA_AUTO];
  wire        wr_ctrl   = wr && (paddr_i == `ACS_OFF_CONTROL_A);
  wire        sw_start  = wr_ctrl && pwdata_i[`ACS_CA_START] && pwdata_i[`ACS_CA_ENABLE];
  wire        sleep_go  = halt_rise && quiet_mode && enabled && single
                          && control_reg[`ACS_CA_IE] && state_reg == ST_IDLE;
  wire        finish    = (state_reg == ST_CONV) && (count_reg == 8'h01);
  wire        abort     = wr_ctrl && !pwdata_i[`ACS_CA_ENABLE];
  wire        done_evt  = finish && !abort;
  wire [7:0]  result_low;
  wire [7:0]  result_high;

  // Alignment is combinational on the stored result, so a flip applies at once
  assign result_low  = select_reg[`ACS_SEL_LEFT] ? {result_reg[1:0], 6'h00} : result_reg[7:0];
  assign result_high = select_reg[`ACS_SEL_LEFT] ? result_reg[9:2] : {6'h00, result_reg[9:8]};

  function [2:0] rd_sel;
    input [11:0] a;
    begin
      if (a == `ACS_OFF_INPUT_SELECT)
        rd_sel = 3'h1;
      else if (a == `ACS_OFF_CONTROL_A)
        rd_sel = 3'h2;
      else if (a == `ACS_OFF_RESULT_LOW)
        rd_sel = 3'h3;
      else if (a == `ACS_OFF_RESULT_HIGH)
        rd_sel = 3'h4;
      else if (a == `ACS_OFF_IRQ_STATUS)
        rd_sel = 3'h5;
      else if (a == `ACS_OFF_IRQ_MASK)
        rd_sel = 3'h6;
      else if (a == `ACS_OFF_SLEEP_CTRL)
        rd_sel = 3'h7;
      else
        rd_sel = 3'h0;
    end
  endfunction

  // Read data mux for one decoded register
  function [31:0] read_word;
    input [2:0] sel;
    input [7:0] sel_val;
    input [7:0] ctl_val;
    input [7:0] low_val;
    input [7:0] high_val;
    input [1:0] stat_val;
    input [1:0] mask_val;
    input [1:0] slp_val;
    begin
      if (sel == RD_SEL)
        read_word = {24'h000000, sel_val};
      else if (sel == RD_CTRL)
        read_word = {24'h000000, ctl_val};
      else if (sel == RD_LOW)
        read_word = {24'h000000, low_val};
      else if (sel == RD_HIGH)
        read_word = {24'h000000, high_val};
      else if (sel == RD_STAT)
        read_word = {30'h00000000, stat_val};
      else if (sel == RD_MASK)
        read_word = {30'h00000000, mask_val};
      else if (sel == RD_SLEEP)
        read_word = {30'h00000000, slp_val};
      else
        read_word = 32'h00000000;
    end
  endfunction

  // Pin inputs pass two flops before use
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      halt_s1_reg   <= 1'b0;
      halt_s2_reg   <= 1'b0;
      halt_prev_reg <= 1'b0;
      mode_s1_reg   <= 2'h0;
      mode_s2_reg   <= 2'h0;
      samp_s1_reg   <= 10'h000;
      samp_s2_reg   <= 10'h000;
    end
    else
    begin
      halt_s1_reg   <= cpu_halted_i;
      halt_s2_reg   <= halt_s1_reg;
      halt_prev_reg <= halt_s2_reg;
      mode_s1_reg   <= sleep_mode_i;
      mode_s2_reg   <= mode_s1_reg;
      samp_s1_reg   <= sample_i;
      samp_s2_reg   <= samp_s1_reg;
    end
  end

  // Registers, conversion sequencer and bus
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg      <= ST_IDLE;
      select_reg     <= 8'h00;
      control_reg    <= 8'h00;
      result_reg     <= 10'h000;
      count_reg      <= 8'h00;
      first_reg      <= 1'b1;
      chan_lat_reg   <= 4'h0;
      ref_lat_reg    <= 2'h0;
      sleep_conv_reg <= 1'b0;
    end
    else
    begin
      if (wr && paddr_i == `ACS_OFF_INPUT_SELECT)
        select_reg <= pwdata_i[7:0] & `ACS_SEL_WMASK;
      if (wr_ctrl)
      begin
        control_reg[`ACS_CA_ENABLE] <= pwdata_i[`ACS_CA_ENABLE];
        control_reg[`ACS_CA_AUTO]   <= pwdata_i[`ACS_CA_AUTO];
        control_reg[`ACS_CA_IE]     <= pwdata_i[`ACS_CA_IE];
        control_reg[2:0]            <= pwdata_i[2:0];
        if (pwdata_i[`ACS_CA_DONE])
          control_reg[`ACS_CA_DONE] <= 1'b0;
        if (!pwdata_i[`ACS_CA_ENABLE])
          first_reg <= 1'b1;
      end
      // Selection tracks the register until a conversion starts
      if (state_reg == ST_IDLE)
      begin
        chan_lat_reg <= select_reg[`ACS_SEL_CH_HI:`ACS_SEL_CH_LO];
        ref_lat_reg  <= select_reg[`ACS_SEL_REF_HI:`ACS_SEL_REF_LO];
      end
      case (state_reg)
        ST_IDLE:
        begin
          if (sw_start || sleep_go)
          begin
            state_reg                  <= ST_CONV;
            control_reg[`ACS_CA_START] <= 1'b1;
            count_reg                  <= first_reg ? `ACS_FIRST_CYCLES : `ACS_CONV_CYCLES;
            first_reg                  <= 1'b0;
            sleep_conv_reg             <= sleep_go;
          end
        end
        ST_CONV:
        begin
          count_reg <= count_reg - 8'h01;
          if (abort)
          begin
            // Disabling aborts the conversion with no result
            state_reg                  <= ST_IDLE;
            control_reg[`ACS_CA_START] <= 1'b0;
            sleep_conv_reg             <= 1'b0;
          end
          else if (finish)
          begin
            result_reg                <= samp_s2_reg;
            control_reg[`ACS_CA_DONE] <= 1'b1;
            sleep_conv_reg <= 1'b0;
            if (single)
            begin
              state_reg                  <= ST_IDLE;
              control_reg[`ACS_CA_START] <= 1'b0;
            end
            else
              count_reg <= `ACS_CONV_CYCLES;
          end
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // Zero-wait slave: ready, error and read data launch in the setup cycle,
  // so they stand at the access edge where the master samples them
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      prdata_o  <= 32'h00000000;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end
    else
    begin
      pready_o  <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & (rd_sel(paddr_i) == RD_NONE);
      if (rd_setup)
        prdata_o <= read_word(rd_sel(paddr_i), select_reg, control_reg, result_low, result_high,
                              irq_stat_reg, irq_mask_reg, sleep_ctrl_reg);
    end
  end

  // Interrupt mask and sleep control storage
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      irq_mask_reg   <= 2'h0;
      sleep_ctrl_reg <= 2'h0;
    end
    else
    begin
      if (wr && paddr_i == `ACS_OFF_IRQ_MASK)
        irq_mask_reg <= pwdata_i[1:0];
      if (wr && paddr_i == `ACS_OFF_SLEEP_CTRL)
        sleep_ctrl_reg <= pwdata_i[1:0];
    end
  end

  // Sticky status, cleared at the edge that latches its read data;
  // a completion in that same edge wins, so no event is lost
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      irq_stat_reg <= 2'h0;
    else
    begin
      if (rd_setup && paddr_i == `ACS_OFF_IRQ_STATUS)
        irq_stat_reg <= 2'h0;
      if (done_evt)
        irq_stat_reg[0] <= 1'b1;
      if (done_evt && sleep_conv_reg)
        irq_stat_reg[1] <= 1'b1;
    end
  end

  // Registered analog controls and busy flag
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      channel_o        <= 4'h0;
      reference_o      <= 2'h0;
      int_ref_on_o     <= 1'b0;
      temp_sensor_on_o <= 1'b0;
      converter_on_o   <= 1'b0;
      busy_o           <= 1'b0;
    end
    else
    begin
      channel_o        <= chan_lat_reg;
      reference_o      <= ref_lat_reg;
      int_ref_on_o     <= (ref_lat_reg == `ACS_REF_INT);
      temp_sensor_on_o <= (chan_lat_reg == `ACS_CH_TEMP);
      // Sleep mode never gates power here; software must clear enable
      converter_on_o   <= enabled;
      busy_o           <= (state_reg == ST_CONV);
    end
  end

  // Interrupt and wake outputs
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      done_irq_o <= 1'b0;
      wake_o     <= 1'b0;
      irq_o      <= 1'b0;
    end
    else
    begin
      // Request stays up until software clears the flag, even after an early wake
      done_irq_o <= control_reg[`ACS_CA_DONE] & control_reg[`ACS_CA_IE];
      // An aborted conversion must not wake the core
      wake_o     <= done_evt & sleep_conv_reg & halt_s2_reg;
      irq_o      <= |(irq_stat_reg & irq_mask_reg);
    end
  end

endmodule
`default_nettype wire

// ---- design/acs_map.vh ----
// Register map, field positions and timing constants of the converter control block
`ifndef ACS_MAP_VH
`define ACS_MAP_VH
`define ACS_OFF_INPUT_SELECT   12'h07C
`define ACS_OFF_CONTROL_A      12'h07A
`define ACS_OFF_RESULT_LOW     12'h078
`define ACS_OFF_RESULT_HIGH    12'h079
`define ACS_OFF_IRQ_STATUS     12'h080
`define ACS_OFF_IRQ_MASK       12'h084
`define ACS_OFF_SLEEP_CTRL     12'h088
`define ACS_ADDR_W             12
// Input select fields
`define ACS_SEL_REF_HI         7
`define ACS_SEL_REF_LO         6
`define ACS_SEL_LEFT           5
`define ACS_SEL_CH_HI          3
`define ACS_SEL_CH_LO          0
`define ACS_SEL_WMASK          8'hEF
// Control A fields
`define ACS_CA_ENABLE          7
`define ACS_CA_START           6
`define ACS_CA_AUTO            5
`define ACS_CA_DONE            4
`define ACS_CA_IE              3
// Reference codes
`define ACS_REF_EXT            2'h0
`define ACS_REF_SUPPLY         2'h1
`define ACS_REF_RSVD           2'h2
`define ACS_REF_INT            2'h3
// Channel codes
`define ACS_CH_TEMP            4'h8
`define ACS_CH_BANDGAP         4'hE
`define ACS_CH_GROUND          4'hF
// Sleep mode codes
`define ACS_SLP_NONE           2'h0
`define ACS_SLP_IDLE           2'h1
`define ACS_SLP_LOWNOISE       2'h2
`define ACS_SLP_OTHER          2'h3
// Conversion length in system clocks, first conversion longer
`define ACS_CONV_CYCLES        8'h0D
`define ACS_FIRST_CYCLES       8'h19
`define ACS_RESULT_MAX         10'h3FF
`endif

// ---- verif/acs_converter_ctrl_monitor.sv ----
// Port checker of the converter control block
`default_nettype none
module acs_converter_ctrl_monitor (
  input wire logic       clock_i,
  input wire logic       rst_n_i,
  input wire logic       psel_i,
  input wire logic       penable_i,
  input wire logic       pready_o,
  input wire logic       pslverr_o,
  input wire logic [1:0] sleep_mode_i,
  input wire logic       cpu_halted_i,
  input wire logic [3:0] channel_o,
  input wire logic [1:0] reference_o,
  input wire logic       int_ref_on_o,
  input wire logic       temp_sensor_on_o,
  input wire logic       converter_on_o,
  input wire logic       busy_o,
  input wire logic       wake_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  sequence setup_s; psel_i && !penable_i; endsequence
  sequence answer_s; pready_o ##1 !pready_o; endsequence
  sequence sleep_entry_s;
    $rose(cpu_halted_i) && (sleep_mode_i == 2'h1 || sleep_mode_i == 2'h2) && converter_on_o && !busy_o;
  endsequence
  ready_pulse_a: assert property (setup_s |=> answer_s) else $error("ready not one cycle after setup");
  error_with_ready_a: assert property (pslverr_o |-> pready_o) else $error("slave error without ready");
  temp_sensor_a: assert property (temp_sensor_on_o == (channel_o == 4'h8))
    else $error("sensor enable disagrees with channel");
  int_ref_a: assert property (int_ref_on_o == (reference_o == 2'h3))
    else $error("internal reference disagrees with code");
  select_frozen_a: assert property (busy_o && $past(busy_o) |-> $stable({reference_o, channel_o}))
    else $error("selection moved during conversion");
  wake_pulse_a: assert property (wake_o |=> !wake_o) else $error("wake longer than one cycle");
  sleep_start_a: assert property (sleep_entry_s |-> ##[1:8] busy_o)
    else $error("no conversion after halt");
  busy_length_a: assert property ($rose(busy_o) |-> busy_o [*8])
    else $error("conversion ended too early");
endmodule
bind acs_converter_ctrl acs_converter_ctrl_monitor acs_converter_ctrl_monitor_i (.*);
`default_nettype wire

// ---- verif/acs_converter_ctrl_tb.sv ----
// Self-checking bench of the converter control block
`default_nettype none
`include "acs_map.vh"
module acs_converter_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_i = 1'b0, rst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic        go = 1'b0, oirq = 1'b0, woke = 1'b0, last_err;
  logic [1:0]  gm = 2'h0, sleep_mode_i, reference_o;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, rdata, prdata_o;
  logic [9:0]  sample_i = 10'h000;
  logic [3:0]  channel_o;
  logic [3:0]  chs [5] = '{4'h0, 4'h7, 4'h8, 4'hE, 4'hF};
  logic        pready_o, pslverr_o, cpu_halted_i, int_ref_on_o, temp_sensor_on_o;
  logic        converter_on_o, busy_o, done_irq_o, wake_o, irq_o;
  int          mismatches = 0, total_checks = 0, cycles = 0;
  always #2.5 clock_i = ~clock_i;
  acs_converter_ctrl acs_converter_ctrl_i (.*);
  acs_cpu_model acs_cpu_model_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .sleep_go_i(go), .sleep_req_i(gm),
    .other_irq_i(oirq), .wake_i(wake_o), .sleep_mode_o(sleep_mode_i), .cpu_halted_o(cpu_halted_i));
  always @(posedge clock_i)
  begin
    if (wake_o === 1'b1) woke <= 1'b1;
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      finish_test();
    end
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // Request held until the rising edge that samples ready high; data taken there
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_i);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, 1'b0, w, a, d};
    @(posedge clock_i);
    penable_i <= 1'b1;
    @(posedge clock_i);
    while (pready_o !== 1'b1) @(posedge clock_i);
    rdata = prdata_o;
    last_err = pslverr_o;
    {psel_i, penable_i} <= 2'b00;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string n);
    xfer(1'b0, a, 32'h0);
    chk(n, e, rdata);
  endtask
  task automatic wait_busy(input logic v);
    int i;
    i = 0;
    while (busy_o !== v && i < 300)
    begin
      @(negedge clock_i);
      i++;
    end
  endtask
  task automatic pulse(input logic g, input logic [1:0] m);
    @(posedge clock_i);
    {go, oirq, gm} <= {g, !g, m};
    @(posedge clock_i);
    {go, oirq} <= 2'b00;
  endtask
  initial
  begin
    repeat (3) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rdc(`ACS_OFF_INPUT_SELECT, 32'h0, "select reset");
    rdc(`ACS_OFF_CONTROL_A, 32'h0, "control reset");
    xfer(1'b1, `ACS_OFF_INPUT_SELECT, 32'hFF);
    rdc(`ACS_OFF_INPUT_SELECT, 32'hEF, "unused bit");
    rdc(12'h0F0, 32'h0, "unmapped data");
    chk("unmapped error", 32'h1, 32'(last_err));
    foreach (chs[k])
      for (int r = 0; r < 4; r++)
      begin
        xfer(1'b1, `ACS_OFF_INPUT_SELECT, {24'h0, r[1:0], 2'b00, chs[k]});
        repeat (3) @(negedge clock_i);
        chk("reference", 32'(r), 32'(reference_o));
        chk("channel", 32'(chs[k]), 32'(channel_o));
        chk("internal ref", 32'(r == 3), 32'(int_ref_on_o));
        chk("temp sensor", 32'(chs[k] == 4'h8), 32'(temp_sensor_on_o));
      end
    sample_i <= 10'h2A5; // Held still through the conversion
    xfer(1'b1, `ACS_OFF_INPUT_SELECT, 32'h43);
    xfer(1'b1, `ACS_OFF_IRQ_MASK, 32'h1);
    xfer(1'b1, `ACS_OFF_CONTROL_A, 32'hC8);
    rdc(`ACS_OFF_CONTROL_A, 32'hC8, "start busy");
    xfer(1'b1, `ACS_OFF_INPUT_SELECT, 32'hC3);
    chk("reference held", 32'h1, 32'(reference_o));
    wait_busy(1'b0);
    repeat (2) @(negedge clock_i);
    chk("reference applied", 32'h3, 32'(reference_o));
    chk("done irq", 32'h1, 32'(done_irq_o));
    chk("irq", 32'h1, 32'(irq_o));
    rdc(`ACS_OFF_CONTROL_A, 32'h98, "done, start clear");
    rdc(`ACS_OFF_RESULT_LOW, 32'hA5, "low right");
    rdc(`ACS_OFF_RESULT_HIGH, 32'h02, "high right");
    xfer(1'b1, `ACS_OFF_INPUT_SELECT, 32'hE3);
    rdc(`ACS_OFF_RESULT_LOW, 32'h40, "low left");
    rdc(`ACS_OFF_RESULT_HIGH, 32'hA9, "high left");
    rdc(`ACS_OFF_IRQ_STATUS, 32'h1, "status");
    @(negedge clock_i);
    chk("irq cleared", 32'h0, 32'(irq_o));
    rdc(`ACS_OFF_IRQ_STATUS, 32'h0, "status cleared");
    xfer(1'b1, `ACS_OFF_IRQ_MASK, 32'h0);
    for (int m = 1; m < 3; m++)
    begin
      xfer(1'b1, `ACS_OFF_CONTROL_A, 32'h98);
      sample_i <= 10'h3FF;
      woke = 1'b0;
      pulse(1'b1, m[1:0]);
      wait_busy(1'b1);
      wait_busy(1'b0);
      repeat (3) @(negedge clock_i);
      chk("woken", 32'h1, 32'(woke));
      chk("masked irq", 32'h0, 32'(irq_o));
      rdc(`ACS_OFF_RESULT_HIGH, 32'hFF, "top code");
      rdc(`ACS_OFF_IRQ_STATUS, 32'h3, "sleep status");
    end
    xfer(1'b1, `ACS_OFF_CONTROL_A, 32'h98);
    woke = 1'b0;
    pulse(1'b1, 2'h1);
    wait_busy(1'b1);
    pulse(1'b0, 2'h0);
    wait_busy(1'b0);
    repeat (3) @(negedge clock_i);
    chk("early wake", 32'h0, 32'(woke));
    chk("request raised", 32'h1, 32'(done_irq_o));
    chk("stays awake", 32'h0, 32'(cpu_halted_i));
    pulse(1'b1, 2'h3);
    repeat (10) @(negedge clock_i);
    chk("still enabled", 32'h1, 32'(converter_on_o));
    chk("no start", 32'h0, 32'(busy_o));
    pulse(1'b0, 2'h0);
    finish_test();
  end
endmodule
`default_nettype wire

// ---- verif/acs_cpu_model.sv ----
// Processor core and sleep controller stand-in
`default_nettype none
module acs_cpu_model (
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic       sleep_go_i,
  input  wire logic [1:0] sleep_req_i,
  input  wire logic       other_irq_i,
  input  wire logic       wake_i,
  output var  logic [1:0] sleep_mode_o,
  output var  logic       cpu_halted_o
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clock_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      sleep_mode_o <= 2'h0;
      cpu_halted_o <= 1'b0;
    end
    else if (sleep_go_i) // Halts on any sleep command, whatever the converter settings
    begin
      sleep_mode_o <= sleep_req_i;
      cpu_halted_o <= 1'b1;
    end
    else if (wake_i || other_irq_i) // Awake until the next sleep command
    begin
      sleep_mode_o <= 2'h0;
      cpu_halted_o <= 1'b0;
    end
endmodule
`default_nettype wire
